// File: scan_seq_pkg.sv
// Constants, register map and carrier types of the scan sequencer
package scan_seq_pkg;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [3:0] CFG_ADDR = 4'h1;
  localparam logic [3:0] INSEL_ADDR = 4'h6;
  localparam logic [3:0] SCAN_ADDR = 4'h7;
  localparam logic [3:0] TIMER_ADDR = 4'h8;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_CONV_LSB = 2;
  localparam int CFG_GAIN_LSB = 4;
  localparam int CFG_FMT_LSB = 7;
  localparam int SCAN_DLY_LSB = 20;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  localparam logic [23:0] INSEL_RESET = 24'h000001;
  localparam logic [23:0] SCAN_RESET = 24'h000000;
  localparam logic [23:0] TIMER_RESET = 24'h000000;

  // ************************************************************
  // Modes and codes
  // ************************************************************
  localparam logic [1:0] PWR_SHUTDOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h2;
  localparam logic [1:0] PWR_CONVERT = 2'h3;
  localparam logic [1:0] CONV_CONTINUOUS = 2'h3;
  localparam logic [1:0] FMT_TAGGED = 2'h3;
  localparam logic [2:0] GAIN_THIRD = 3'h0;
  localparam logic [2:0] GAIN_ONE = 3'h1;

  // ************************************************************
  // Channels and forced input selections
  // ************************************************************
  localparam logic [3:0] CH_OFFSET = 4'hF;
  localparam logic [3:0] CH_COMMON = 4'hE;
  localparam logic [3:0] CH_SUPPLY = 4'hD;
  localparam logic [3:0] CH_TEMP = 4'hC;
  localparam logic [3:0] CH_DIFF = 4'h8;
  localparam logic [3:0] CH_SE1 = 4'h1;
  localparam logic [3:0] CH_SE0 = 4'h0;
  localparam logic [7:0] SEL_OFFSET = 8'h88;
  localparam logic [7:0] SEL_COMMON = 8'hF8;
  localparam logic [7:0] SEL_SUPPLY = 8'h98;
  localparam logic [7:0] SEL_TEMP = 8'hDE;
  localparam logic [7:0] SEL_DIFF = 8'h01;
  localparam logic [7:0] SEL_SE1 = 8'h18;
  localparam logic [7:0] SEL_SE0 = 8'h08;

  // ************************************************************
  // Timing in filter clock periods
  // ************************************************************
  localparam logic [23:0] STARTUP_PERIODS = 24'h000100;
  localparam logic [23:0] DLY_UNIT = 24'h000004;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_INTRA = 2'b10,
    ST_GAP = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic [7:0] input_selection;
    logic [2:0] gain;
    logic offset_short;
    logic [1:0] power_state;
  } analog_cfg_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [23:0] wdata;
    logic wr;
  } reg_req_t;

endpackage

// File: tick_down_counter.sv
// Loadable down-counter advancing on filter clock ticks
`timescale 1ns/1ps
module tick_down_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [23:0] load_value,
  input wire logic tick,
  // Status
  output logic [23:0] count,
  output logic at_zero
);

  logic [23:0] count_ff;
  logic [23:0] nxt_count;

  assign nxt_count = load ? load_value :
                     (tick && count_ff != 24'h000000) ? count_ff - 24'h000001 : count_ff;
  assign count = count_ff;
  assign at_zero = (count_ff == 24'h000000);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_ff <= 24'h000000;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule

// File: scan_sequencer.sv
// Scan sequencer: channel stepping, forced settings, delays and power control
`timescale 1ns/1ps
module scan_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire scan_seq_pkg::reg_req_t reg_req,
  output logic [23:0] reg_rdata,
  // Converter handshake
  input wire logic filter_tick,
  input wire logic conv_done,
  output logic conv_start,
  // Analog control
  output scan_seq_pkg::analog_cfg_t analog_cfg,
  // Result tagging
  output logic [3:0] channel_tag,
  output logic tag_enable,
  output logic scan_busy
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [23:0] cfg_ff;
  logic [23:0] insel_ff;
  logic [23:0] scan_ff;
  logic [23:0] timer_ff;
  scan_seq_pkg::seq_state_t state_ff;
  scan_seq_pkg::seq_state_t nxt_state;
  logic [3:0] chan_ff;
  logic [3:0] nxt_chan;
  logic conv_start_ff;
  logic nxt_conv_start;
  logic [23:0] reg_rdata_ff;
  scan_seq_pkg::analog_cfg_t analog_cfg_ff;
  scan_seq_pkg::analog_cfg_t nxt_analog_cfg;
  logic [3:0] channel_tag_ff;
  logic tag_enable_ff;
  logic scan_busy_ff;

  // ************************************************************
  // Decoding
  // ************************************************************
  function automatic logic [4:0] pick_top(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  wire wr_cfg = reg_req.wr && reg_req.addr == scan_seq_pkg::CFG_ADDR;
  wire wr_insel = reg_req.wr && reg_req.addr == scan_seq_pkg::INSEL_ADDR;
  wire wr_scan = reg_req.wr && reg_req.addr == scan_seq_pkg::SCAN_ADDR;
  wire wr_timer = reg_req.wr && reg_req.addr == scan_seq_pkg::TIMER_ADDR;
  // Gain and format follow a write in its own cycle, so a restart starts with them
  wire [23:0] live_cfg = wr_cfg ? reg_req.wdata : cfg_ff;
  wire [1:0] adc_mode = cfg_ff[scan_seq_pkg::CFG_MODE_LSB +: 2];
  wire [1:0] conv_mode = cfg_ff[scan_seq_pkg::CFG_CONV_LSB +: 2];
  wire [2:0] prog_gain = live_cfg[scan_seq_pkg::CFG_GAIN_LSB +: 3];
  wire [1:0] data_fmt = live_cfg[scan_seq_pkg::CFG_FMT_LSB +: 2];
  // Host keeps unavailable mask bits clear, so they are used as written
  wire [15:0] mask = scan_ff[15:0];
  wire [2:0] dly_code = scan_ff[scan_seq_pkg::SCAN_DLY_LSB +: 3];
  wire scan_mode = |mask;
  wire [4:0] first_pick = pick_top(mask);
  wire [15:0] below = mask & 16'((16'h0001 << chan_ff) - 16'h0001);
  wire [4:0] next_pick = pick_top(below);
  wire busy = state_ff != scan_seq_pkg::ST_IDLE;
  wire [1:0] new_mode = reg_req.wdata[scan_seq_pkg::CFG_MODE_LSB +: 2];
  wire start_cfg = wr_cfg && new_mode == scan_seq_pkg::PWR_CONVERT && scan_mode;
  wire start_scan_wr = wr_scan && (|reg_req.wdata[15:0]) &&
                       adc_mode == scan_seq_pkg::PWR_CONVERT &&
                       state_ff != scan_seq_pkg::ST_GAP;
  wire start_timer_wr = wr_timer && state_ff == scan_seq_pkg::ST_GAP;
  wire restart = start_cfg || start_scan_wr || start_timer_wr;
  wire [15:0] live_mask = wr_scan ? reg_req.wdata[15:0] : mask;
  wire [4:0] restart_pick = pick_top(live_mask);
  wire live_scan = |live_mask;
  // Intra delay is 4 shifted by the code: 8 for code 1 up to 512 for code 7
  wire [23:0] intra_len = 24'(scan_seq_pkg::DLY_UNIT << dly_code);
  wire shutdown_case = timer_ff >= scan_seq_pkg::STARTUP_PERIODS;

  // ************************************************************
  // Delay counters
  // ************************************************************
  wire [23:0] intra_count;
  wire intra_zero;
  wire [23:0] gap_count;
  wire gap_zero;
  wire end_conv = state_ff == scan_seq_pkg::ST_CONV && conv_done;
  wire has_next = next_pick[4];
  wire load_intra = end_conv && has_next && dly_code != 3'h0 && !restart;
  wire load_gap = end_conv && !has_next && conv_mode == scan_seq_pkg::CONV_CONTINUOUS &&
                  !restart;

  tick_down_counter intra_cnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(load_intra),
    .load_value(intra_len),
    .tick(filter_tick),
    .count(intra_count),
    .at_zero(intra_zero)
  );

  tick_down_counter gap_cnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(load_gap),
    .load_value(timer_ff),
    .tick(filter_tick),
    .count(gap_count),
    .at_zero(gap_zero)
  );

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_chan = chan_ff;
    nxt_conv_start = 1'b0;
    if (restart) begin
      nxt_state = scan_seq_pkg::ST_CONV;
      nxt_chan = restart_pick[3:0];
      nxt_conv_start = 1'b1;
    end else begin
      case (state_ff)
        scan_seq_pkg::ST_IDLE: begin
          nxt_state = scan_seq_pkg::ST_IDLE;
        end
        scan_seq_pkg::ST_CONV: begin
          if (conv_done && has_next) begin
            nxt_chan = next_pick[3:0];
            if (dly_code == 3'h0) begin
              nxt_conv_start = 1'b1;
            end else begin
              nxt_state = scan_seq_pkg::ST_INTRA;
            end
          end else if (conv_done) begin
            nxt_state = (conv_mode == scan_seq_pkg::CONV_CONTINUOUS) ?
                        scan_seq_pkg::ST_GAP : scan_seq_pkg::ST_IDLE;
          end
        end
        scan_seq_pkg::ST_INTRA: begin
          if (intra_zero) begin
            nxt_state = scan_seq_pkg::ST_CONV;
            nxt_conv_start = 1'b1;
          end
        end
        scan_seq_pkg::ST_GAP: begin
          if (gap_zero) begin
            nxt_state = scan_seq_pkg::ST_CONV;
            nxt_chan = first_pick[3:0];
            nxt_conv_start = 1'b1;
          end
        end
        default: begin
          nxt_state = scan_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Effective analog settings
  // ************************************************************
  always_comb begin
    nxt_analog_cfg.input_selection = insel_ff[7:0];
    nxt_analog_cfg.gain = prog_gain;
    nxt_analog_cfg.offset_short = 1'b0;
    if (live_scan) begin
      case (nxt_chan)
        scan_seq_pkg::CH_OFFSET: begin
          nxt_analog_cfg.input_selection = scan_seq_pkg::SEL_OFFSET;
          nxt_analog_cfg.offset_short = 1'b1;
        end
        scan_seq_pkg::CH_COMMON: begin
          nxt_analog_cfg.input_selection = scan_seq_pkg::SEL_COMMON;
          nxt_analog_cfg.gain = scan_seq_pkg::GAIN_ONE;
        end
        scan_seq_pkg::CH_SUPPLY: begin
          nxt_analog_cfg.input_selection = scan_seq_pkg::SEL_SUPPLY;
          nxt_analog_cfg.gain = scan_seq_pkg::GAIN_THIRD;
        end
        scan_seq_pkg::CH_TEMP: begin
          nxt_analog_cfg.input_selection = scan_seq_pkg::SEL_TEMP;
          nxt_analog_cfg.gain = scan_seq_pkg::GAIN_ONE;
        end
        scan_seq_pkg::CH_DIFF: begin
          nxt_analog_cfg.input_selection = scan_seq_pkg::SEL_DIFF;
        end
        scan_seq_pkg::CH_SE1: begin
          nxt_analog_cfg.input_selection = scan_seq_pkg::SEL_SE1;
        end
        default: begin
          nxt_analog_cfg.input_selection = scan_seq_pkg::SEL_SE0;
        end
      endcase
    end
    case (nxt_state)
      scan_seq_pkg::ST_CONV: begin
        nxt_analog_cfg.power_state = scan_seq_pkg::PWR_CONVERT;
      end
      scan_seq_pkg::ST_INTRA: begin
        nxt_analog_cfg.power_state = scan_seq_pkg::PWR_STANDBY;
      end
      scan_seq_pkg::ST_GAP: begin
        if (!shutdown_case) begin
          nxt_analog_cfg.power_state = scan_seq_pkg::PWR_STANDBY;
        end else if (load_gap ? timer_ff > scan_seq_pkg::STARTUP_PERIODS :
                     gap_count > scan_seq_pkg::STARTUP_PERIODS) begin
          nxt_analog_cfg.power_state = scan_seq_pkg::PWR_SHUTDOWN;
        end else begin
          nxt_analog_cfg.power_state = scan_seq_pkg::PWR_CONVERT;
        end
      end
      default: begin
        nxt_analog_cfg.power_state = adc_mode;
      end
    endcase
  end

  // ************************************************************
  // Register file and readback
  // ************************************************************
  logic [23:0] rd_mux;
  always_comb begin
    case (reg_req.addr)
      scan_seq_pkg::CFG_ADDR: begin
        rd_mux = cfg_ff;
        if (busy) begin
          rd_mux[scan_seq_pkg::CFG_MODE_LSB +: 2] = scan_seq_pkg::PWR_CONVERT;
        end
      end
      scan_seq_pkg::INSEL_ADDR: begin
        rd_mux = insel_ff;
      end
      scan_seq_pkg::SCAN_ADDR: begin
        rd_mux = scan_ff;
      end
      scan_seq_pkg::TIMER_ADDR: begin
        rd_mux = timer_ff;
      end
      default: begin
        rd_mux = 24'h000000;
      end
    endcase
  end

  wire one_shot_end = end_conv && !has_next && conv_mode != scan_seq_pkg::CONV_CONTINUOUS;
  wire [1:0] park_mode = (conv_mode == scan_seq_pkg::PWR_STANDBY) ?
                         scan_seq_pkg::PWR_STANDBY : scan_seq_pkg::PWR_SHUTDOWN;

  // Stored fields change only by host writes or a one-shot end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ff <= scan_seq_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_ff <= reg_req.wdata;
    end else if (one_shot_end && !restart) begin
      cfg_ff[scan_seq_pkg::CFG_MODE_LSB +: 2] <= park_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      insel_ff <= scan_seq_pkg::INSEL_RESET;
      scan_ff <= scan_seq_pkg::SCAN_RESET;
      timer_ff <= scan_seq_pkg::TIMER_RESET;
    end else begin
      insel_ff <= wr_insel ? {16'h0000, reg_req.wdata[7:0]} : insel_ff;
      scan_ff <= wr_scan ? {1'b0, reg_req.wdata[22:0]} : scan_ff;
      timer_ff <= wr_timer ? reg_req.wdata : timer_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= scan_seq_pkg::ST_IDLE;
      chan_ff <= 4'h0;
      conv_start_ff <= 1'b0;
      analog_cfg_ff <= '0;
      reg_rdata_ff <= 24'h000000;
      channel_tag_ff <= 4'h0;
      tag_enable_ff <= 1'b0;
      scan_busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      chan_ff <= nxt_chan;
      conv_start_ff <= nxt_conv_start;
      analog_cfg_ff <= nxt_analog_cfg;
      reg_rdata_ff <= rd_mux;
      channel_tag_ff <= nxt_chan;
      tag_enable_ff <= live_scan && data_fmt == scan_seq_pkg::FMT_TAGGED;
      scan_busy_ff <= nxt_state != scan_seq_pkg::ST_IDLE;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign conv_start = conv_start_ff;
  assign analog_cfg = analog_cfg_ff;
  assign channel_tag = channel_tag_ff;
  assign tag_enable = tag_enable_ff;
  assign scan_busy = scan_busy_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence conv_on(logic [3:0] ch);
    live_scan && nxt_state == scan_seq_pkg::ST_CONV && nxt_chan == ch;
  endsequence

  supply_force_a: assert property (conv_on(scan_seq_pkg::CH_SUPPLY) |=>
    analog_cfg.input_selection == 8'h98 && analog_cfg.gain == scan_seq_pkg::GAIN_THIRD)
    else $error("supply channel not forced");
  temp_force_a: assert property (conv_on(scan_seq_pkg::CH_TEMP) |=>
    analog_cfg.input_selection == 8'hDE && analog_cfg.gain == scan_seq_pkg::GAIN_ONE)
    else $error("temperature channel not forced");
  common_force_a: assert property (conv_on(scan_seq_pkg::CH_COMMON) |=>
    analog_cfg.input_selection == 8'hF8 && analog_cfg.gain == scan_seq_pkg::GAIN_ONE)
    else $error("common-mode channel not forced");
  offset_short_a: assert property (conv_on(scan_seq_pkg::CH_OFFSET) |=>
    analog_cfg.offset_short) else $error("offset channel not shorted");
  cfg_kept_a: assert property (busy && !reg_req.wr && !end_conv |=>
    $stable(cfg_ff)) else $error("stored config changed by scan");
  intra_len_a: assert property ($rose(state_ff == scan_seq_pkg::ST_INTRA) |->
    intra_count == 24'(24'h4 << dly_code)) else $error("intra delay length wrong");
  first_conv_a: assert property (restart |=>
    state_ff == scan_seq_pkg::ST_CONV && conv_start) else $error("delay before first conversion");
  intra_power_a: assert property (state_ff == scan_seq_pkg::ST_INTRA |->
    analog_cfg.power_state == 2'h2) else $error("intra delay not standby");
  mode_read_a: assert property (busy && !reg_req.wr && reg_req.addr == scan_seq_pkg::CFG_ADDR
    |=> reg_rdata[1:0] == 2'h3) else $error("power field not read as 11");
  order_a: assert property (end_conv && has_next && !restart |=>
    chan_ff < $past(chan_ff)) else $error("channel order not descending");
  gap_wake_a: assert property (state_ff == scan_seq_pkg::ST_GAP && shutdown_case &&
    gap_count == 24'h000100 && !restart |=> analog_cfg.power_state == 2'h3)
    else $error("no power-up at 256");
  gap_sleep_a: assert property (state_ff == scan_seq_pkg::ST_GAP &&
    gap_count > 24'h000101 && !restart |=> analog_cfg.power_state == 2'h0)
    else $error("no shutdown in long gap");
  gap_standby_a: assert property (state_ff == scan_seq_pkg::ST_GAP && !shutdown_case &&
    !gap_zero && !restart |=> analog_cfg.power_state == 2'h2)
    else $error("no standby in short gap");
  gap_end_a: assert property (state_ff == scan_seq_pkg::ST_GAP && gap_zero && !restart
    |=> state_ff == scan_seq_pkg::ST_CONV && conv_start) else $error("gap end no restart");

endmodule

// File: conv_model.sv
// Converter stand-in: filter clock ticks and conversion completion
`timescale 1ns/1ps
module conv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Converter link
  input wire logic conv_start,
  output logic filter_tick,
  output logic conv_done
);
  logic [1:0] ph_ff = 2'h0;
  int wait_cnt = -1;
  int seed = 98;
  initial begin
    filter_tick = 1'b0;
    conv_done = 1'b0;
  end
  // ************************************************************
  // Tick every fourth clock, completion two clocks clear of a tick
  // ************************************************************
  always @(posedge clk) begin
    ph_ff <= ph_ff + 2'h1;
    filter_tick <= (ph_ff == 2'h3);
    conv_done <= 1'b0;
    if (sys_rst) begin
      wait_cnt <= -1;
    end else if (conv_start) begin
      wait_cnt <= 3 + ($random(seed) & 7);
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (wait_cnt == 0 && ph_ff == 2'h1) begin
      conv_done <= 1'b1;
      wait_cnt <= -1;
    end
  end
endmodule

// File: tb.sv
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
module tb;
  typedef struct {
    scan_seq_pkg::analog_cfg_t cfg;
    logic [3:0] tag;
    logic en;
    logic mid;
    int ticks;
    int off;
    int stby;
  } note_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  scan_seq_pkg::reg_req_t reg_req = '0;
  logic [23:0] reg_rdata;
  logic filter_tick, conv_done, conv_start, tag_enable, scan_busy;
  logic [3:0] channel_tag;
  scan_seq_pkg::analog_cfg_t analog_cfg;
  note_t notes[$];
  note_t nt;
  logic [23:0] exp_rd = 24'h000000;
  logic rd_due = 1'b0;
  int seed = 98;
  int fails = 0;
  int total_checks = 0;
  int n_tick = 0;
  int n_off = 0;
  int n_stby = 0;
  logic [15:0] masks [8] = '{16'hF103, 16'h3001, 16'h0102, 16'h8000,
    16'hC000, 16'h1100, 16'h0003, 16'hE000};
  int gaps [8] = '{3, 300, 256, 0, 257, 255, 1, 2};

  always #2.5 clk = ~clk;

  scan_sequencer i_dut (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .filter_tick(filter_tick), .conv_done(conv_done), .conv_start(conv_start),
    .analog_cfg(analog_cfg), .channel_tag(channel_tag), .tag_enable(tag_enable),
    .scan_busy(scan_busy));
  conv_model i_conv (.clk(clk), .sys_rst(sys_rst), .conv_start(conv_start),
    .filter_tick(filter_tick), .conv_done(conv_done));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk);
    reg_req <= '{a, d, 1'b1};
    @(posedge clk);
    reg_req <= '{scan_seq_pkg::CFG_ADDR, 24'h000000, 1'b0};
  endtask

  task automatic rd(input logic [3:0] a, input logic [23:0] e);
    @(posedge clk);
    reg_req <= '{a, 24'h000000, 1'b0};
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(reg_rdata, e);
  endtask

  function automatic scan_seq_pkg::analog_cfg_t chan_cfg(input int k, input logic [2:0] g);
    chan_cfg = '{8'h08, g, 1'b0, 2'h3};
    case (k)
      15: chan_cfg = '{8'h88, g, 1'b1, 2'h3};
      14: chan_cfg = '{8'hF8, scan_seq_pkg::GAIN_ONE, 1'b0, 2'h3};
      13: chan_cfg = '{8'h98, scan_seq_pkg::GAIN_THIRD, 1'b0, 2'h3};
      12: chan_cfg = '{8'hDE, scan_seq_pkg::GAIN_ONE, 1'b0, 2'h3};
      8: chan_cfg.input_selection = 8'h01;
      1: chan_cfg.input_selection = 8'h18;
      default: chan_cfg.input_selection = 8'h08;
    endcase
  endfunction

  // Notes two full cycles, starts the scan, then clears the config so the scan ends after the last noted conversion
  task automatic run_scan(input logic [15:0] m, input logic [2:0] d, input int gap,
    input logic [1:0] fmt);
    logic [2:0] g;
    note_t e;
    int w;
    g = 3'($random(seed));
    for (int c = 0; c < 2; c++) begin
      w = 1;
      for (int k = 15; k >= 0; k--) begin
        if (m[k]) begin
          e.cfg = chan_cfg(k, g);
          e.tag = 4'(k);
          e.en = (fmt == 2'h3);
          e.mid = (w == 0);
          e.ticks = (d == 3'h0) ? 0 : (4 << d);
          e.off = 0;
          e.stby = e.ticks;
          if (w == 1) begin
            e.ticks = (c == 0) ? -1 : gap;
            e.off = (gap > 256) ? gap - 256 : 0;
            e.stby = (gap < 256) ? gap : 0;
          end
          w = 0;
          notes.push_back(e);
        end
      end
    end
    exp_rd = {15'h0000, fmt, g, 4'hF};
    wr(scan_seq_pkg::SCAN_ADDR, {1'b0, d, 4'h0, m});
    wr(scan_seq_pkg::TIMER_ADDR, gap[23:0]);
    wr(scan_seq_pkg::CFG_ADDR, exp_rd);
    w = 0;
    while (notes.size() > 0 && w < 20000) begin
      @(negedge clk);
      w++;
    end
    if (w == 20000) begin
      fails++;
      $display("mismatch %0t wait limit reached", $time);
      print_verdict();
    end
    wr(scan_seq_pkg::CFG_ADDR, 24'h000000);
  endtask

  // ************************************************************
  // Result monitor
  // ************************************************************
  always @(posedge clk) begin
    if (rd_due) begin
      chk(reg_rdata, exp_rd);
    end
    rd_due = 1'b0;
    if (sys_rst === 1'b0 && conv_start === 1'b1) begin
      if (notes.size() == 0) begin
        chk(1, 0);
      end else begin
        nt = notes.pop_front();
        chk(analog_cfg, nt.cfg);
        chk(channel_tag, nt.tag);
        chk(tag_enable, nt.en);
        rd_due = 1'b1;
        if (nt.ticks >= 0) begin
          chk(n_tick, nt.ticks);
          chk(n_off, nt.off);
          chk(n_stby, nt.stby);
        end
      end
    end
    if (conv_done === 1'b1 || conv_start === 1'b1) begin
      n_tick = 0;
      n_off = 0;
      n_stby = 0;
    end else if (filter_tick === 1'b1) begin
      n_tick++;
      if (analog_cfg.power_state === 2'h0) n_off++;
      if (analog_cfg.power_state === 2'h2) n_stby++;
      if (notes.size() > 0 && notes[0].mid && analog_cfg.power_state === 2'h2) begin
        chk(analog_cfg.input_selection, notes[0].cfg.input_selection);
      end
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(scan_seq_pkg::INSEL_ADDR, 24'h000001);
    rd(scan_seq_pkg::TIMER_ADDR, 24'h000000);
    wr(scan_seq_pkg::TIMER_ADDR, 24'hFFFFFF);
    rd(scan_seq_pkg::TIMER_ADDR, 24'hFFFFFF);
    wr(4'hF, 24'hFFFFFF);
    rd(4'hF, 24'h000000);
    wr(scan_seq_pkg::SCAN_ADDR, 24'hF00000);
    rd(scan_seq_pkg::SCAN_ADDR, 24'h700000);
    for (int i = 0; i < 8; i++) begin
      run_scan(masks[i], 3'(i), gaps[i], (i == 2) ? 2'h0 : 2'h3);
    end
    wr(scan_seq_pkg::INSEL_ADDR, 24'h00005A);
    wr(scan_seq_pkg::SCAN_ADDR, 24'h000000);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(analog_cfg.input_selection, 8'h5A);
    chk(scan_busy, 1'b0);
    print_verdict();
  end
endmodule
